// File: scs_spi_map.vh
`ifndef SCS_SPI_MAP_VH
`define SCS_SPI_MAP_VH

// ****************************************
// command addresses
// ****************************************
`define SCS_ADDR_STATE      8'h19
`define SCS_ADDR_STATUS     8'h1a
`define SCS_ADDR_TEMP       8'h1b
`define SCS_ADDR_INFO       8'h1c
`define SCS_ADDR_READBACK   8'h1d

// ****************************************
// framing
// ****************************************
`define SCS_BYTE_BITS       8
`define SCS_BIT_LAST        3'h7
`define SCS_DATA_MIN        3'h1
`define SCS_DATA_MAX        3'h4
`define SCS_RB_WIDTH        40
`define SCS_RB_LOAD_BITS    32
`define SCS_STATUS_BITS     16

// ****************************************
// states, one-hot
// ****************************************
`define SCS_ST_LATCH        4'h1
`define SCS_ST_ADDR         4'h2
`define SCS_ST_DATA         4'h4
`define SCS_ST_BUSY         4'h8

// ****************************************
// timing
// ****************************************
`define SCS_CLK_MHZ         10
`define SCS_PROC_MIN_US     40
`define SCS_PROC_MAX_US     150
`define SCS_PROC_MIN_CYC    (`SCS_PROC_MIN_US * `SCS_CLK_MHZ)
`define SCS_PROC_MAX_CYC    (`SCS_PROC_MAX_US * `SCS_CLK_MHZ)
`define SCS_PROC_CNT_W      11
`define SCS_LATCH_CYCLES    10000000
`define SCS_LATCH_CNT_W     24

`endif

// File: scs_sync.v
`timescale 1ns/1ps
`default_nettype none

module scs_sync #(
  parameter integer WIDTH = 4
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  input  wire [WIDTH-1:0] d_i,
  output reg  [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta;

  // ****************************************
  // two-stage synchroniser, first stage read only by second
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {WIDTH{1'b0}};
      q_o  <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

`default_nettype wire

// File: scs_spi_slave.v
// Behaviour
// - after a full transfer ready_out drops and incoming data is ignored.
// - ready_out rises when processing ends; host waits for it or 300 us.
// - a write is one transfer of 2 to 5 bytes, address first.
// - device waits for exactly the register's byte count; short transfer hangs.
// - processing finishes 40 to 150 us after reception.
// - mode strap sampled after reset; high selects mode 1, low mode 0.
// - mode 1 shifts on falling clock edges, mode 0 on rising edges.
// - every byte travels most significant bit first.
// - readback buffer shifts out, most significant byte first, during every transfer except those ignored while busy.
// - query result read by 5-byte transfer to 0x1d with four zero bytes.
// - readback register data is zero and serviced on the serial port only.
// - status query returns only the two lowest bytes valid; others all four.
// - reading the readback register clears the output buffer.
`timescale 1ns/1ps
`default_nettype none
`include "scs_spi_map.vh"

module scs_spi_slave #(
  parameter integer LATCH_CYCLES = `SCS_LATCH_CYCLES
) (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire        clk_en_i,
  input  wire        spi_cs_n_i,
  input  wire        spi_sclk_i,
  input  wire        spi_mosi_i,
  output reg         spi_miso_o,
  output reg         spi_miso_oe_o,
  input  wire        mode_strap_i,
  output reg         ready_out_o,
  output reg         clk_mode_o,
  output reg  [7:0]  hdr_addr_o,
  input  wire [2:0]  data_len_i,
  output reg         cmd_valid_o,
  output reg  [7:0]  cmd_addr_o,
  output reg  [31:0] cmd_data_o,
  output reg  [2:0]  cmd_len_o,
  input  wire        cmd_done_i,
  input  wire        rb_load_i,
  input  wire [31:0] rb_data_i
);

  // ****************************************
  // synchronised pins and edge detection
  // ****************************************
  wire cs_s;
  wire sclk_s;
  wire mosi_s;
  wire strap_s;
  reg  sclk_d;

  scs_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_i (clk_sys_i),
    .rst_i (sys_rst_i),
    .ce_i  (clk_en_i),
    .d_i   ({mode_strap_i, spi_mosi_i, spi_sclk_i, ~spi_cs_n_i}),
    .q_o   ({strap_s, mosi_s, sclk_s, cs_s})
  );

  // select synced active high so the cleared stages read as deselected after reset
  wire cs_n_s = ~cs_s;

  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire act_edge  = clk_mode_o ? sclk_fall : sclk_rise;
  wire bit_stb   = act_edge & ~cs_n_s;

  // ****************************************
  // state
  // ****************************************
  reg [3:0]                     state;
  reg [`SCS_LATCH_CNT_W-1:0]    latch_cnt;
  reg [`SCS_PROC_CNT_W-1:0]     proc_cnt;
  reg [2:0]                     bit_cnt;
  reg [7:0]                     rx_shift;
  reg [2:0]                     bytes_left;
  reg [2:0]                     bytes_got;
  reg [31:0]                    data_acc;
  reg [`SCS_RB_WIDTH-1:0]       rb;
  reg                           rb_is_status;
  reg                           local_cmd;

  wire [7:0] rx_byte   = {rx_shift[6:0], mosi_s};
  wire       byte_done = bit_stb && (bit_cnt == `SCS_BIT_LAST);

  // clamp the register's byte count into the legal 1..4 range
  reg [2:0] next_len;
  always @* begin
    next_len = data_len_i;
    if (rx_byte == `SCS_ADDR_READBACK) begin
      next_len = `SCS_DATA_MAX;
    end else if (data_len_i < `SCS_DATA_MIN) begin
      next_len = `SCS_DATA_MIN;
    end else if (data_len_i > `SCS_DATA_MAX) begin
      next_len = `SCS_DATA_MAX;
    end
  end

  // busy lasts the minimum time, then ends on done from the processor or the ceiling, or right at the minimum for a readback command
  wire proc_min_done = (proc_cnt >= `SCS_PROC_MIN_CYC - 1);
  wire proc_max_done = (proc_cnt >= `SCS_PROC_MAX_CYC - 1);
  wire proc_end      = proc_min_done && (local_cmd || cmd_done_i || proc_max_done);

  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state         <= `SCS_ST_LATCH;
      latch_cnt     <= {`SCS_LATCH_CNT_W{1'b0}};
      proc_cnt      <= {`SCS_PROC_CNT_W{1'b0}};
      sclk_d        <= 1'b0;
      bit_cnt       <= 3'h0;
      rx_shift      <= 8'h00;
      bytes_left    <= 3'h0;
      bytes_got     <= 3'h0;
      data_acc      <= 32'h0000_0000;
      rb            <= {`SCS_RB_WIDTH{1'b0}};
      rb_is_status  <= 1'b0;
      local_cmd     <= 1'b0;
      clk_mode_o    <= 1'b1;
      ready_out_o   <= 1'b0;
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
      hdr_addr_o    <= 8'h00;
      cmd_valid_o   <= 1'b0;
      cmd_addr_o    <= 8'h00;
      cmd_data_o    <= 32'h0000_0000;
      cmd_len_o     <= 3'h0;
    end else if (clk_en_i) begin
      sclk_d        <= sclk_s;
      cmd_valid_o   <= 1'b0;
      // miso always shows the buffer msb; the pin is driven only under select
      spi_miso_oe_o <= ~cs_n_s;
      spi_miso_o    <= rb[`SCS_RB_WIDTH-1];

      // query results arrive while busy; status keeps only the low two bytes
      if (rb_load_i) begin
        rb <= {{(`SCS_RB_WIDTH-`SCS_RB_LOAD_BITS){1'b0}},
               (rb_is_status ? {{(`SCS_RB_LOAD_BITS-`SCS_STATUS_BITS){1'b0}},
                                rb_data_i[`SCS_STATUS_BITS-1:0]}
                             : rb_data_i)};
      end

      case (state)
        `SCS_ST_LATCH: begin
          ready_out_o <= 1'b0;
          if (latch_cnt >= LATCH_CYCLES[`SCS_LATCH_CNT_W-1:0] - 1'b1) begin
            clk_mode_o  <= strap_s;
            ready_out_o <= 1'b1;
            rb          <= {`SCS_RB_WIDTH{1'b0}};
            // re-seed the edge finder so the idle clock level is not taken as an edge
            sclk_d      <= sclk_s;
            state       <= `SCS_ST_ADDR;
          end else begin
            latch_cnt <= latch_cnt + 1'b1;
          end
        end
        `SCS_ST_ADDR, `SCS_ST_DATA: begin
          if (cs_n_s) begin
            bit_cnt <= 3'h0;
          end else if (bit_stb) begin
            bit_cnt  <= bit_cnt + 1'b1;
            rx_shift <= rx_byte;
            rb       <= {rb[`SCS_RB_WIDTH-2:0], 1'b0};
          end
          // address byte picks the data byte count for this register
          if (byte_done && (state == `SCS_ST_ADDR)) begin
            hdr_addr_o <= rx_byte;
            bytes_left <= next_len;
            bytes_got  <= 3'h0;
            data_acc   <= 32'h0000_0000;
            state      <= `SCS_ST_DATA;
          end else if (byte_done) begin
            data_acc   <= {data_acc[23:0], rx_byte};
            bytes_left <= bytes_left - 1'b1;
            bytes_got  <= bytes_got + 1'b1;
            // stays here across select high until the count is met
            // last data byte: hand the command over and go busy
            if (bytes_left == 3'h1) begin
              ready_out_o  <= 1'b0;
              proc_cnt     <= {`SCS_PROC_CNT_W{1'b0}};
              cmd_addr_o   <= hdr_addr_o;
              cmd_data_o   <= {data_acc[23:0], rx_byte};
              cmd_len_o    <= bytes_got + 1'b1;
              local_cmd    <= (hdr_addr_o == `SCS_ADDR_READBACK);
              cmd_valid_o  <= (hdr_addr_o != `SCS_ADDR_READBACK);
              rb_is_status <= (hdr_addr_o == `SCS_ADDR_STATUS);
              if (hdr_addr_o == `SCS_ADDR_READBACK) begin
                rb <= {`SCS_RB_WIDTH{1'b0}};
              end
              state        <= `SCS_ST_BUSY;
            end
          end
        end
        `SCS_ST_BUSY: begin
          // serial traffic is dropped while processing
          bit_cnt <= 3'h0;
          if (proc_end) begin
            ready_out_o <= 1'b1;
            state       <= `SCS_ST_ADDR;
          end else begin
            proc_cnt <= proc_cnt + 1'b1;
          end
        end
        default: begin
          state <= `SCS_ST_LATCH;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// File: scs_spi_props.sv
`timescale 1ns/1ps
`default_nettype none
module scs_spi_props (
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic       spi_cs_n_i,
  input wire logic       spi_miso_oe_o,
  input wire logic       ready_out_o,
  input wire logic       clk_mode_o,
  input wire logic       cmd_valid_o,
  input wire logic       cmd_done_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic        up;
  logic [10:0] lo_cnt;
  sequence s_release;
    ##[1:3] ready_out_o;
  endsequence
  // cycles spent busy since ready was last high
  always_ff @(posedge clk_sys_i) begin
    up <= !sys_rst_i && (up || ready_out_o);
    lo_cnt <= (sys_rst_i || ready_out_o) ? 11'h000 : lo_cnt + {10'h000, lo_cnt != 11'h7ff};
  end
  AST_VALID_RDY: assert property (cmd_valid_o |-> !ready_out_o)
    else $error("ready high with command pulse");
  AST_IGNORE_BUSY: assert property (!ready_out_o && !$past(ready_out_o) |-> !cmd_valid_o)
    else $error("command taken while busy");
  AST_BUSY_MIN: assert property (up && $rose(ready_out_o) |-> lo_cnt >= 11'h190)
    else $error("busy too short");
  AST_BUSY_MAX: assert property (up && !ready_out_o |-> lo_cnt <= 11'h5dc)
    else $error("busy too long");
  AST_DONE_RELEASE: assert property (up && !ready_out_o && lo_cnt >= 11'h19a && cmd_done_i
    |-> s_release)
    else $error("ready not back after done");
  AST_MODE_HELD: assert property (up |-> $stable(clk_mode_o))
    else $error("mode changed after latch");
  AST_MODE_DEFAULT: assert property (!up && !ready_out_o |-> clk_mode_o)
    else $error("mode not 1 before latch");
  AST_OE_SELECT: assert property ($fell(spi_cs_n_i) |-> ##[1:4] spi_miso_oe_o)
    else $error("output not driven under select");
endmodule
`default_nettype wire

// File: scs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scs_host_model (
  input  wire logic clk_i,
  input  wire logic mode_i,
  input  wire logic miso_i,
  output var  logic cs_n_o,
  output var  logic sclk_o,
  output var  logic mosi_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    mosi_o = 1'b0;
  end
  // n whole bytes under one select, 800 ns clock, idle level per mode
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = 40'h0;
    sclk_o <= mode_i;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (10) @(posedge clk_i);
    for (int b = 0; b < n * 8; b++) begin
      mosi_o <= tx[n * 8 - 1 - b];
      repeat (4) @(posedge clk_i);
      sclk_o <= ~mode_i;
      rx = {rx[38:0], miso_i};
      repeat (4) @(posedge clk_i);
      sclk_o <= mode_i;
      if (b % 8 == 7) repeat (70) @(posedge clk_i);
    end
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
  endtask
endmodule
`default_nettype wire

// File: scs_spi_slave_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scs_spi_map.vh"
module scs_spi_slave_tb_top;
  logic clk_sys_i, sys_rst_i, clk_en_i, spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o;
  logic spi_miso_oe_o, mode_strap_i, ready_out_o, clk_mode_o, cmd_valid_o, cmd_done_i;
  logic rb_load_i, host_mode;
  logic [7:0] hdr_addr_o, cmd_addr_o;
  logic [2:0] data_len_i, cmd_len_o;
  logic [31:0] cmd_data_o, rb_data_i;
  logic [39:0] rx;
  int fail_count = 0, n_compared = 0, n_valid = 0;
  scs_spi_slave #(.LATCH_CYCLES(20)) uut (
    .clk_sys_i     (clk_sys_i),
    .sys_rst_i     (sys_rst_i),
    .clk_en_i      (clk_en_i),
    .spi_cs_n_i    (spi_cs_n_i),
    .spi_sclk_i    (spi_sclk_i),
    .spi_mosi_i    (spi_mosi_i),
    .spi_miso_o    (spi_miso_o),
    .spi_miso_oe_o (spi_miso_oe_o),
    .mode_strap_i  (mode_strap_i),
    .ready_out_o   (ready_out_o),
    .clk_mode_o    (clk_mode_o),
    .hdr_addr_o    (hdr_addr_o),
    .data_len_i    (data_len_i),
    .cmd_valid_o   (cmd_valid_o),
    .cmd_addr_o    (cmd_addr_o),
    .cmd_data_o    (cmd_data_o),
    .cmd_len_o     (cmd_len_o),
    .cmd_done_i    (cmd_done_i),
    .rb_load_i     (rb_load_i),
    .rb_data_i     (rb_data_i)
  );
  // an undriven miso line shows the inverse of the last bit
  scs_host_model host (.clk_i(clk_sys_i), .mode_i(host_mode),
    .miso_i(spi_miso_oe_o ? spi_miso_o : ~spi_miso_o),
    .cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i), .mosi_o(spi_mosi_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) if (cmd_valid_o === 1'b1) n_valid <= n_valid + 1;
  task automatic check(string nm, logic [39:0] got, logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_rdy;
    for (int i = 0; i < 3000 && ready_out_o !== 1'b1; i++) @(posedge clk_sys_i);
    check("ready", ready_out_o, 1'b1);
  endtask
  task automatic do_reset(logic strap);
    mode_strap_i <= strap;
    host_mode <= strap;
    sys_rst_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check("ready_rst", ready_out_o, 1'b0);
    wait_rdy();
    check("mode", clk_mode_o, strap);
    mode_strap_i <= ~strap;
  endtask
  task automatic t_write;
    data_len_i <= 3'h2;
    cmd_done_i <= 1'b0;
    host.xfer(40'h05abcd, 3, rx);
    repeat (8) @(posedge clk_sys_i);
    check("busy", ready_out_o, 1'b0);
    check("addr", cmd_addr_o, 8'h05);
    check("hdr", hdr_addr_o, 8'h05);
    check("data", cmd_data_o, 32'h0000abcd);
    check("len", cmd_len_o, 3'h2);
    host.xfer(40'h0701, 2, rx);
    repeat (900) @(posedge clk_sys_i);
    check("pulses", n_valid, 1);
    check("busy_long", ready_out_o, 1'b0);
    cmd_done_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    check("ready_done", ready_out_o, 1'b1);
  endtask
  task automatic t_query(logic [7:0] a, logic [31:0] d, logic [31:0] e);
    check("mode_kept", clk_mode_o, host_mode);
    data_len_i <= 3'h1;
    host.xfer({32'h0, a, 8'h00}, 2, rx);
    rb_data_i <= d;
    rb_load_i <= 1'b1;
    @(posedge clk_sys_i);
    rb_load_i <= 1'b0;
    wait_rdy();
    host.xfer({`SCS_ADDR_READBACK, 32'h0}, 5, rx);
    check("readback", rx, {8'h00, e});
    wait_rdy();
    host.xfer({`SCS_ADDR_READBACK, 32'h0}, 5, rx);
    check("cleared", rx, 40'h0);
    wait_rdy();
  endtask
  initial begin
    {sys_rst_i, clk_en_i, cmd_done_i, mode_strap_i, host_mode} = 5'h1f;
    {data_len_i, rb_load_i, rb_data_i} = 36'h0;
    @(posedge clk_sys_i);
    do_reset(1'b1);
    t_write();
    t_query(`SCS_ADDR_STATE, 32'h12345678, 32'h12345678);
    t_query(`SCS_ADDR_TEMP, 32'h89abcdef, 32'h89abcdef);
    t_query(`SCS_ADDR_INFO, 32'h0badf00d, 32'h0badf00d);
    do_reset(1'b0);
    t_query(`SCS_ADDR_STATUS, 32'hdeadbeef, 32'h0000beef);
    test_done();
  end
  initial begin
    #5000000;
    fail_count++;
    test_done();
  end
endmodule
bind scs_spi_slave scs_spi_props chk (
  .clk_sys_i     (clk_sys_i),
  .sys_rst_i     (sys_rst_i),
  .spi_cs_n_i    (spi_cs_n_i),
  .spi_miso_oe_o (spi_miso_oe_o),
  .ready_out_o   (ready_out_o),
  .clk_mode_o    (clk_mode_o),
  .cmd_valid_o   (cmd_valid_o),
  .cmd_done_i    (cmd_done_i)
);
`default_nettype wire
